// ---- rtl/oscsw_pkg.sv ----
// constants and carrier types for the oscillator switch control block
`default_nettype none
package oscsw_pkg;
   localparam logic [3:0] OSCSW_ADDR_OSC_CTRL = 4'h0;
   localparam logic [3:0] OSCSW_ADDR_CLK_DIV  = 4'h2;
   localparam logic [3:0] OSCSW_ADDR_RC_TUNE  = 4'h4;
   localparam logic [3:0] OSCSW_ADDR_STATUS   = 4'h6;

   localparam int OSCSW_CUR_LSB   = 12;
   localparam int OSCSW_NEW_LSB   = 8;
   localparam int OSCSW_SLOCK_BIT = 7;
   localparam int OSCSW_PLOCK_BIT = 6;
   localparam int OSCSW_PLL_BIT   = 5;
   localparam int OSCSW_FAIL_BIT  = 3;
   localparam int OSCSW_PKEEP_BIT = 2;
   localparam int OSCSW_SEC_BIT   = 1;
   localparam int OSCSW_START_BIT = 0;
   localparam int OSCSW_ROI_BIT   = 15;
   localparam int OSCSW_RATIO_LSB = 12;
   localparam int OSCSW_RATEN_BIT = 11;
   localparam int OSCSW_PSC_LSB   = 8;

   localparam logic [7:0] OSCSW_KEY_HI_1 = 8'h78;
   localparam logic [7:0] OSCSW_KEY_HI_2 = 8'h9A;
   localparam logic [7:0] OSCSW_KEY_LO_1 = 8'h46;
   localparam logic [7:0] OSCSW_KEY_LO_2 = 8'h57;

   localparam logic [2:0] OSCSW_RATIO_RST = 3'h3;
   localparam logic [2:0] OSCSW_PSC_RST   = 3'h1;
   localparam logic [3:0] OSCSW_SETTLE_CYCLES = 4'hA;

   typedef enum logic [2:0] {
      OSCSW_SRC_FRC     = 3'h0,
      OSCSW_SRC_FRC_PLL = 3'h1,
      OSCSW_SRC_PRI     = 3'h2,
      OSCSW_SRC_PRI_PLL = 3'h3,
      OSCSW_SRC_SEC     = 3'h4,
      OSCSW_SRC_LOW_POWER_RC_OSC    = 3'h5,
      OSCSW_SRC_RSVD    = 3'h6,
      OSCSW_SRC_FRC_DIV = 3'h7
   } oscsw_src_t;

   typedef struct packed {
      logic [3:0]  addr;
      logic [15:0] wdata;
      logic [1:0]  byte_en;
      logic        wr;
      logic        rd;
   } oscsw_bus_t;

   typedef struct packed {
      logic [1:0] switch_monitor_cfg;
      logic [2:0] initial_source_cfg;
      logic       pin_lock_one_shot_cfg;
      logic [1:0] primary_submode_cfg;
      logic       watchdog_enabled;
   } oscsw_cfg_t;

   typedef struct packed {
      logic pll_locked;
      logic osc_startup_done;
      logic fail_detect;
      logic new_clk_tick;
      logic irq;
   } oscsw_ana_t;
endpackage
`default_nettype wire

// ---- rtl/oscsw_ctrl.sv ----
// oscillator source selection, unlock keys, switch sequencer and divider control
//
// The address-and-strobe port and the register addresses are this design's own decisions.
`default_nettype none
module oscsw_ctrl
   import oscsw_pkg::*;
(
   input  wire  logic        clk,
   input  wire  logic        rst,
   input  wire  logic        ce,
   input  wire  oscsw_bus_t  bus,
   input  wire  oscsw_cfg_t  cfg_pin,
   input  wire  oscsw_ana_t  ana_pin,
   output logic [15:0]       rdata,
   output logic [2:0]        sys_src,
   output logic [7:0]        osc_enable,
   output logic              primary_keep_in_sleep,
   output logic [2:0]        doze_ratio_eff,
   output logic [2:0]        fast_rc_postscale,
   output logic [5:0]        fast_rc_trim,
   output logic              pin_map_lock
);
   typedef enum logic [1:0] {
      OSCSW_ST_IDLE   = 2'b00,
      OSCSW_ST_WAIT   = 2'b01,
      OSCSW_ST_SETTLE = 2'b11
   } oscsw_state_t;
   function automatic logic src_uses_pll(input logic [2:0] s);
      src_uses_pll = (s == OSCSW_SRC_FRC_PLL) || (s == OSCSW_SRC_PRI_PLL);
   endfunction
   function automatic logic [7:0] src_onehot(input logic [2:0] s);
      src_onehot = 8'h01 << s;
   endfunction
   // configuration and analog inputs come from outside the clock domain
   oscsw_cfg_t cfg_s1_reg;
   oscsw_cfg_t cfg_reg;
   oscsw_ana_t ana_s1_reg;
   oscsw_ana_t ana_reg;
   logic       tick_d_reg;
   logic       irq_d_reg;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cfg_s1_reg <= '0;
         cfg_reg    <= '0;
         ana_s1_reg <= '0;
         ana_reg    <= '0;
         tick_d_reg <= 1'b0;
         irq_d_reg  <= 1'b0;
      end else if (ce) begin
         cfg_s1_reg <= cfg_pin;
         cfg_reg    <= cfg_s1_reg;
         ana_s1_reg <= ana_pin;
         ana_reg    <= ana_s1_reg;
         tick_d_reg <= ana_reg.new_clk_tick;
         irq_d_reg  <= ana_reg.irq;
      end
   end
   logic tick_rise;
   logic irq_rise;
   assign tick_rise = ana_reg.new_clk_tick & ~tick_d_reg;
   assign irq_rise  = ana_reg.irq & ~irq_d_reg;
   logic switch_allowed;
   logic monitor_on;
   assign switch_allowed = (cfg_reg.switch_monitor_cfg == 2'b00);
   assign monitor_on     = (cfg_reg.switch_monitor_cfg == 2'b00);
   // straps are taken a few cycles after reset release, once synchronised
   logic [1:0] boot_cnt_reg;
   logic       boot_done;
   assign boot_done = (boot_cnt_reg == 2'h3);
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         boot_cnt_reg <= 2'h0;
      end else if (ce && !boot_done) begin
         boot_cnt_reg <= boot_cnt_reg + 2'h1;
      end
   end
   logic boot_load;
   assign boot_load = (boot_cnt_reg == 2'h2);
   logic wr_ctrl;
   logic wr_hi;
   logic wr_lo;
   assign wr_ctrl = bus.wr && (bus.addr == OSCSW_ADDR_OSC_CTRL);
   assign wr_hi   = wr_ctrl && bus.byte_en[1];
   assign wr_lo   = wr_ctrl && bus.byte_en[0];
   // key tracking: 0 none, 1 first key seen, 2 unlocked for the next write
   logic [1:0] key_hi_reg;
   logic [1:0] key_lo_reg;
   logic       hi_open;
   logic       lo_open;
   assign hi_open = (key_hi_reg == 2'h2) && wr_hi;
   assign lo_open = (key_lo_reg == 2'h2) && wr_lo;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         key_hi_reg <= 2'h0;
      end else if (ce && bus.wr) begin
         if (wr_hi && key_hi_reg == 2'h0 && bus.wdata[15:8] == OSCSW_KEY_HI_1) begin
            key_hi_reg <= 2'h1;
         end else if (wr_hi && key_hi_reg == 2'h1 && bus.wdata[15:8] == OSCSW_KEY_HI_2) begin
            key_hi_reg <= 2'h2;
         end else if (wr_hi && bus.wdata[15:8] == OSCSW_KEY_HI_1) begin
            key_hi_reg <= 2'h1;
         end else begin
            key_hi_reg <= 2'h0;
         end
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         key_lo_reg <= 2'h0;
      end else if (ce && bus.wr) begin
         if (wr_lo && key_lo_reg == 2'h0 && bus.wdata[7:0] == OSCSW_KEY_LO_1) begin
            key_lo_reg <= 2'h1;
         end else if (wr_lo && key_lo_reg == 2'h1 && bus.wdata[7:0] == OSCSW_KEY_LO_2) begin
            key_lo_reg <= 2'h2;
         end else if (wr_lo && bus.wdata[7:0] == OSCSW_KEY_LO_1) begin
            key_lo_reg <= 2'h1;
         end else begin
            key_lo_reg <= 2'h0;
         end
      end
   end
   logic [2:0]   cur_src_reg;
   logic [2:0]   new_src_reg;
   logic         sel_lock_reg;
   logic         pin_lock_reg;
   logic         pll_lock_reg;
   logic         fail_reg;
   logic         keep_reg;
   logic         sec_en_reg;
   logic         start_reg;
   oscsw_state_t state_reg;
   logic [3:0]   settle_reg;
   logic [7:0]   osc_on_reg;
   logic sel_frozen;
   assign sel_frozen = monitor_on && sel_lock_reg;
   logic start_req;
   assign start_req = lo_open && bus.wdata[OSCSW_START_BIT] && switch_allowed
                      && !sel_frozen && state_reg == OSCSW_ST_IDLE && !start_reg;
   logic redundant;
   assign redundant = (new_src_reg == cur_src_reg);
   // during a switch the lock bit follows the source being brought up
   logic [2:0] lock_src;
   assign lock_src = (state_reg == OSCSW_ST_IDLE) ? cur_src_reg : new_src_reg;
   logic src_ready;
   assign src_ready = src_uses_pll(new_src_reg) ? ana_reg.pll_locked
                    : (new_src_reg == OSCSW_SRC_PRI) ? ana_reg.osc_startup_done
                    : 1'b1;
   logic changeover;
   assign changeover = (state_reg == OSCSW_ST_SETTLE) && tick_rise
                       && (settle_reg == OSCSW_SETTLE_CYCLES - 4'h1);
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_reg  <= OSCSW_ST_IDLE;
         settle_reg <= 4'h0;
      end else if (ce) begin
         case (state_reg)
            OSCSW_ST_IDLE: begin
               if (start_req && !redundant) begin
                  state_reg <= OSCSW_ST_WAIT;
               end
            end
            OSCSW_ST_WAIT: begin
               settle_reg <= 4'h0;
               if (src_ready) begin
                  state_reg <= OSCSW_ST_SETTLE;
               end
            end
            OSCSW_ST_SETTLE: begin
               if (tick_rise) begin
                  settle_reg <= settle_reg + 4'h1;
               end
               if (changeover) begin
                  state_reg <= OSCSW_ST_IDLE;
               end
            end
            default: begin
               state_reg <= OSCSW_ST_IDLE;
            end
         endcase
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         start_reg <= 1'b0;
      end else if (ce) begin
         if (!switch_allowed) begin
            start_reg <= 1'b0;
         end else if (start_req) begin
            start_reg <= !redundant;
         end else if (changeover) begin
            start_reg <= 1'b0;
         end
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cur_src_reg <= OSCSW_SRC_FRC_DIV;
         new_src_reg <= OSCSW_SRC_FRC_DIV;
      end else if (ce) begin
         if (boot_load || !switch_allowed) begin
            cur_src_reg <= cfg_reg.initial_source_cfg;
         end else if (changeover) begin
            cur_src_reg <= new_src_reg;
         end
         if (boot_load) begin
            new_src_reg <= cfg_reg.initial_source_cfg;
         end else if (hi_open && !sel_frozen && state_reg == OSCSW_ST_IDLE) begin
            new_src_reg <= bus.wdata[OSCSW_NEW_LSB +: 3];
         end
      end
   end
   // oscillators stay on while in use, wanted, or needed by others
   logic [7:0] keep_mask;
   assign keep_mask = (cfg_reg.watchdog_enabled || monitor_on ? src_onehot(OSCSW_SRC_LOW_POWER_RC_OSC) : 8'h00)
                    | (sec_en_reg ? src_onehot(OSCSW_SRC_SEC) : 8'h00);
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         osc_on_reg <= 8'h00;
      end else if (ce) begin
         if (boot_load) begin
            osc_on_reg <= src_onehot(cfg_reg.initial_source_cfg) | keep_mask;
         end else if (changeover) begin
            osc_on_reg <= src_onehot(new_src_reg) | keep_mask;
         end else if (state_reg != OSCSW_ST_IDLE) begin
            osc_on_reg <= osc_on_reg | src_onehot(new_src_reg) | keep_mask;
         end else begin
            osc_on_reg <= (osc_on_reg & src_onehot(cur_src_reg)) | keep_mask;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pll_lock_reg <= 1'b0;
      end else if (ce) begin
         if (!src_uses_pll(lock_src) || (start_req && !redundant)) begin
            pll_lock_reg <= 1'b0;
         end else begin
            pll_lock_reg <= ana_reg.pll_locked;
         end
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         fail_reg <= 1'b0;
      end else if (ce) begin
         if (monitor_on && ana_reg.fail_detect) begin
            fail_reg <= 1'b1;
         end else if (start_req && !redundant) begin
            fail_reg <= 1'b0;
         end else if (lo_open && !bus.wdata[OSCSW_FAIL_BIT]) begin
            fail_reg <= 1'b0;
         end
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sel_lock_reg <= 1'b0;
         pin_lock_reg <= 1'b0;
         keep_reg     <= 1'b0;
         sec_en_reg   <= 1'b0;
      end else if (ce && lo_open) begin
         sel_lock_reg <= sel_lock_reg | bus.wdata[OSCSW_SLOCK_BIT];
         if (!(cfg_reg.pin_lock_one_shot_cfg && pin_lock_reg)) begin
            pin_lock_reg <= bus.wdata[OSCSW_PLOCK_BIT];
         end
         keep_reg   <= bus.wdata[OSCSW_PKEEP_BIT];
         sec_en_reg <= bus.wdata[OSCSW_SEC_BIT];
      end
   end
   logic       roi_reg;
   logic [2:0] ratio_reg;
   logic       ratio_en_reg;
   logic [2:0] psc_reg;
   logic [5:0] trim_reg;
   logic       wr_div;
   assign wr_div = bus.wr && bus.addr == OSCSW_ADDR_CLK_DIV && bus.byte_en[1];
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         roi_reg      <= 1'b0;
         ratio_reg    <= OSCSW_RATIO_RST;
         ratio_en_reg <= 1'b0;
         psc_reg      <= OSCSW_PSC_RST;
      end else if (ce) begin
         if (wr_div) begin
            roi_reg   <= bus.wdata[OSCSW_ROI_BIT];
            ratio_reg <= bus.wdata[OSCSW_RATIO_LSB +: 3];
            psc_reg   <= bus.wdata[OSCSW_PSC_LSB +: 3];
         end
         if (roi_reg && irq_rise) begin
            ratio_en_reg <= 1'b0;
         end else if (wr_div) begin
            ratio_en_reg <= bus.wdata[OSCSW_RATEN_BIT];
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         trim_reg <= 6'h00;
      end else if (ce && bus.wr && bus.addr == OSCSW_ADDR_RC_TUNE && bus.byte_en[0]) begin
         trim_reg <= bus.wdata[5:0];
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata <= 16'h0000;
      end else if (ce) begin
         rdata <= 16'h0000;
         if (bus.rd) begin
            case (bus.addr)
               OSCSW_ADDR_OSC_CTRL: rdata <= {1'b0, cur_src_reg, 1'b0, new_src_reg, sel_lock_reg,
                                             pin_lock_reg, pll_lock_reg, 1'b0, fail_reg, keep_reg,
                                             sec_en_reg, start_reg};
               OSCSW_ADDR_CLK_DIV:  rdata <= {roi_reg, ratio_reg, ratio_en_reg, psc_reg, 8'h00};
               OSCSW_ADDR_RC_TUNE:  rdata <= {10'h000, trim_reg};
               OSCSW_ADDR_STATUS:   rdata <= {6'h00, cfg_reg.primary_submode_cfg, osc_on_reg};
               default:             rdata <= 16'h0000;
            endcase
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sys_src               <= OSCSW_SRC_FRC_DIV;
         osc_enable            <= 8'h00;
         primary_keep_in_sleep <= 1'b0;
         doze_ratio_eff        <= 3'h0;
         fast_rc_postscale     <= OSCSW_PSC_RST;
         fast_rc_trim          <= 6'h00;
         pin_map_lock          <= 1'b0;
      end else if (ce) begin
         sys_src               <= cur_src_reg;
         osc_enable            <= osc_on_reg;
         primary_keep_in_sleep <= keep_reg;
         doze_ratio_eff        <= ratio_en_reg ? ratio_reg : 3'h0;
         fast_rc_postscale     <= psc_reg;
         fast_rc_trim          <= trim_reg;
         pin_map_lock          <= pin_lock_reg;
      end
   end
endmodule
`default_nettype wire

// ---- tb/oscsw_ctrl_sva.sv ----
// assertion checker for the oscillator switch control block
`default_nettype none
module oscsw_ctrl_sva
   import oscsw_pkg::*;
(
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        ce,
   input wire oscsw_bus_t  bus,
   input wire oscsw_cfg_t  cfg_pin,
   input wire oscsw_ana_t  ana_pin,
   input wire logic [15:0] rdata,
   input wire logic [2:0]  sys_src,
   input wire logic [7:0]  osc_enable,
   input wire logic        primary_keep_in_sleep,
   input wire logic [2:0]  doze_ratio_eff,
   input wire logic [2:0]  fast_rc_postscale,
   input wire logic [5:0]  fast_rc_trim,
   input wire logic        pin_map_lock
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [3:0] boot_cnt;
   logic [7:0] tick_cnt;
   logic [3:0] irq_age;
   logic       tick_q;
   logic       irq_q;
   logic [2:0] src_q;
   wire logic  boot_done = boot_cnt >= 4'h8;
   wire logic  rd_osc    = bus.rd && ce && bus.addr == OSCSW_ADDR_OSC_CTRL;
   wire logic  lo_wr     = bus.wr && ce && bus.addr == OSCSW_ADDR_OSC_CTRL && bus.byte_en[0];
   wire logic  div_wr    = bus.wr && ce && bus.addr == OSCSW_ADDR_CLK_DIV && bus.byte_en[1];
   wire logic  tune_wr   = bus.wr && ce && bus.addr == OSCSW_ADDR_RC_TUNE && bus.byte_en[0];

   always_ff @(posedge clk or posedge rst) begin
      if (rst) boot_cnt <= 4'h0;
      else if (boot_cnt != 4'hF) boot_cnt <= boot_cnt + 4'h1;
   end

   // raw tick edges since the last source change
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tick_q   <= 1'b0;
         src_q    <= 3'h0;
         tick_cnt <= 8'h00;
      end else begin
         tick_q <= ana_pin.new_clk_tick;
         src_q  <= sys_src;
         if (src_q != sys_src) tick_cnt <= 8'h00;
         else if (ana_pin.new_clk_tick && !tick_q && tick_cnt != 8'hFF) tick_cnt <= tick_cnt + 8'h01;
      end
   end

   // cycles since the last raw interrupt edge
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         irq_q   <= 1'b0;
         irq_age <= 4'hF;
      end else begin
         irq_q <= ana_pin.irq;
         if (ana_pin.irq && !irq_q) irq_age <= 4'h0;
         else if (irq_age != 4'hF) irq_age <= irq_age + 4'h1;
      end
   end

   default clocking @(posedge clk);
   endclocking
   default disable iff (rst);

   AST_SRC_FIXED: assert property (boot_done && cfg_pin.switch_monitor_cfg[1] |-> sys_src == cfg_pin.initial_source_cfg)
      else $error("source moved while switching disabled");
   AST_START_LOW: assert property ($past(rd_osc) && boot_done && cfg_pin.switch_monitor_cfg[1] |-> !rdata[0])
      else $error("start bit seen while switching disabled");
   AST_TEN_TICKS: assert property (boot_done && $changed(sys_src) |-> tick_cnt >= 8'h0A)
      else $error("changeover before ten new clock ticks");
   AST_NEW_POWERED: assert property (boot_done && $changed(sys_src) |-> ##[0:2] osc_enable[sys_src])
      else $error("new source not powered after changeover");
   AST_KEEP_CAUSE: assert property ($changed(primary_keep_in_sleep) |-> $past(lo_wr) || $past(lo_wr, 2))
      else $error("sleep keep bit changed without a write");
   AST_PIN_ONE_WAY: assert property (boot_done && cfg_pin.pin_lock_one_shot_cfg |-> !$fell(pin_map_lock))
      else $error("pin lock cleared in one-way mode");
   AST_PSC_CAUSE: assert property ($changed(fast_rc_postscale) |-> $past(div_wr) || $past(div_wr, 2))
      else $error("postscaler changed without a write");
   AST_TRIM_CAUSE: assert property ($changed(fast_rc_trim) |-> $past(tune_wr) || $past(tune_wr, 2))
      else $error("trim changed without a write");
   AST_RATIO_CAUSE: assert property ($changed(doze_ratio_eff) |-> $past(div_wr) || $past(div_wr, 2) || irq_age < 4'h8)
      else $error("ratio changed without write or interrupt");
   AST_PLL_NON_PLL: assert property ($past(rd_osc) && boot_done && !(rdata[14:12] inside {3'h1, 3'h3})
      && !(rdata[10:8] inside {3'h1, 3'h3}) |-> !rdata[5])
      else $error("pll lock bit set in a non-pll mode");

   COV_SWITCH: cover property (boot_done && $changed(sys_src));
   COV_RECOVER: cover property (irq_age == 4'h6 && doze_ratio_eff == 3'h0);
   COV_PIN_LOCK: cover property ($rose(pin_map_lock));
endmodule

bind oscsw_ctrl oscsw_ctrl_sva chk_u (
   .clk(clk), .rst(rst), .ce(ce), .bus(bus), .cfg_pin(cfg_pin), .ana_pin(ana_pin), .rdata(rdata),
   .sys_src(sys_src), .osc_enable(osc_enable), .primary_keep_in_sleep(primary_keep_in_sleep),
   .doze_ratio_eff(doze_ratio_eff), .fast_rc_postscale(fast_rc_postscale), .fast_rc_trim(fast_rc_trim),
   .pin_map_lock(pin_map_lock)
);
`default_nettype wire

// ---- tb/oscsw_ctrl_tb.sv ----
// register-level testbench for the oscillator switch control block
`default_nettype none
module oscsw_ctrl_tb
   import oscsw_pkg::*;
();
   timeunit 1ns;
   timeprecision 100ps;
   logic        clk;
   logic        rst;
   logic        ce;
   oscsw_bus_t  bus;
   oscsw_cfg_t  cfg_pin;
   oscsw_ana_t  ana_pin;
   logic [15:0] rdata;
   logic [2:0]  sys_src;
   logic [7:0]  osc_enable;
   logic        primary_keep_in_sleep;
   logic [2:0]  doze_ratio_eff;
   logic [2:0]  fast_rc_postscale;
   logic [5:0]  fast_rc_trim;
   logic        pin_map_lock;
   int          fail_count;
   int          num_checks;
   logic [5:0]  trims [4] = '{6'h00, 6'h1F, 6'h20, 6'h3F};

   oscsw_ctrl dut_u (
      .clk(clk), .rst(rst), .ce(ce), .bus(bus), .cfg_pin(cfg_pin), .ana_pin(ana_pin), .rdata(rdata),
      .sys_src(sys_src), .osc_enable(osc_enable), .primary_keep_in_sleep(primary_keep_in_sleep),
      .doze_ratio_eff(doze_ratio_eff), .fast_rc_postscale(fast_rc_postscale), .fast_rc_trim(fast_rc_trim),
      .pin_map_lock(pin_map_lock)
   );

   task automatic summarize();
      if (fail_count == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic idle(input int n);
      bus.wr <= 1'b0;
      bus.rd <= 1'b0;
      repeat (n) @(posedge clk);
   endtask

   task automatic wr(input logic [3:0] a, input logic [1:0] be, input logic [15:0] d);
      bus <= '{addr: a, wdata: d, byte_en: be, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
   endtask

   task automatic rchk(input string name, input logic [3:0] a, input logic [15:0] exp);
      bus <= '{addr: a, wdata: 16'h0000, byte_en: 2'b00, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      bus.rd <= 1'b0;
      #1;
      check(name, exp, rdata);
      @(posedge clk);
   endtask

   // key pair then the protected byte, all on one lane
   task automatic unlock(input logic hi, input logic [15:0] d);
      wr(4'h0, hi ? 2'b10 : 2'b01, hi ? 16'h7800 : 16'h0046);
      wr(4'h0, hi ? 2'b10 : 2'b01, hi ? 16'h9A00 : 16'h0057);
      wr(4'h0, hi ? 2'b10 : 2'b01, d);
      idle(3);
   endtask

   task automatic ticks(input int n);
      repeat (n) begin
         ana_pin.new_clk_tick <= 1'b1;
         repeat (2) @(posedge clk);
         ana_pin.new_clk_tick <= 1'b0;
         repeat (2) @(posedge clk);
      end
   endtask

   task automatic pulse(input logic is_irq);
      if (is_irq) ana_pin.irq <= 1'b1;
      else ana_pin.fail_detect <= 1'b1;
      idle(4);
      if (is_irq) ana_pin.irq <= 1'b0;
      else ana_pin.fail_detect <= 1'b0;
      idle(6);
   endtask

   task automatic boot(input oscsw_cfg_t c);
      rst <= 1'b1;
      cfg_pin <= c;
      idle(8);
      rst <= 1'b0;
      idle(6);
   endtask

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   initial begin
      #400000;
      fail_count++;
      summarize();
   end

   initial begin
      rst = 1'b1;
      ce = 1'b1;
      bus = '0;
      cfg_pin = '0;
      ana_pin = '0;
      fail_count = 0;
      num_checks = 0;
      @(posedge clk);
      boot('{2'b00, 3'h0, 1'b0, 2'b00, 1'b0});
      rchk("osc rst", 4'h0, 16'h0000);
      rchk("div rst", 4'h2, 16'h3100);
      rchk("tune rst", 4'h4, 16'h0000);
      rchk("unmapped", 4'h8, 16'h0000);
      wr(4'h0, 2'b10, 16'h0300);
      idle(2);
      rchk("no keys", 4'h0, 16'h0000);
      wr(4'h0, 2'b10, 16'h7800);
      wr(4'h2, 2'b10, 16'h3100);
      wr(4'h0, 2'b10, 16'h9A00);
      wr(4'h0, 2'b10, 16'h0300);
      idle(2);
      rchk("broken keys", 4'h0, 16'h0000);
      unlock(1'b1, 16'h0100);
      rchk("new sel", 4'h0, 16'h0100);
      pulse(1'b0);
      rchk("fail set", 4'h0, 16'h0108);
      unlock(1'b0, 16'h000D);
      rchk("started", 4'h0, 16'h0105);
      ticks(12);
      @(negedge clk);
      check("no lock", 16'h0000, {13'h0, sys_src});
      check("new on", 16'h0002, {8'h00, osc_enable & 8'h02});
      @(posedge clk);
      rchk("wait lock", 4'h0, 16'h0105);
      ana_pin.pll_locked <= 1'b1;
      idle(4);
      ticks(9);
      idle(6);
      @(negedge clk);
      check("nine ticks", 16'h0000, {13'h0, sys_src});
      @(posedge clk);
      ticks(1);
      idle(6);
      @(negedge clk);
      check("switched", 16'h0001, {13'h0, sys_src});
      check("power", 16'h0022, {8'h00, osc_enable});
      check("keep", 16'h0001, {15'h0, primary_keep_in_sleep});
      @(posedge clk);
      rchk("after sw", 4'h0, 16'h1124);
      unlock(1'b0, 16'h0007);
      rchk("redundant", 4'h0, 16'h1126);
      pulse(1'b0);
      rchk("fail again", 4'h0, 16'h112E);
      unlock(1'b1, 16'h0000);
      unlock(1'b0, 16'h0009);
      rchk("valid start", 4'h0, 16'h1001);
      ana_pin.pll_locked <= 1'b0;
      ticks(10);
      idle(6);
      @(negedge clk);
      check("back", 16'h0000, {13'h0, sys_src});
      check("power 2", 16'h0021, {8'h00, osc_enable});
      check("keep 2", 16'h0000, {15'h0, primary_keep_in_sleep});
      @(posedge clk);
      rchk("frc", 4'h0, 16'h0000);
      unlock(1'b0, 16'h0040);
      rchk("pin lock", 4'h0, 16'h0040);
      wr(4'h0, 2'b01, 16'h0000);
      idle(3);
      @(negedge clk);
      check("pin kept", 16'h0001, {15'h0, pin_map_lock});
      @(posedge clk);
      unlock(1'b0, 16'h0000);
      @(negedge clk);
      check("pin free", 16'h0000, {15'h0, pin_map_lock});
      @(posedge clk);
      unlock(1'b0, 16'h0080);
      unlock(1'b1, 16'h0200);
      unlock(1'b0, 16'h0000);
      rchk("sel lock", 4'h0, 16'h0080);
      for (int i = 0; i < 8; i++) begin
         wr(4'h2, 2'b10, {5'h00, i[2:0], 8'h00});
         idle(3);
         @(negedge clk);
         check("postscale", {13'h0, i[2:0]}, {13'h0, fast_rc_postscale});
         @(posedge clk);
      end
      wr(4'h2, 2'b10, 16'hF800);
      idle(3);
      @(negedge clk);
      check("ratio on", 16'h0007, {13'h0, doze_ratio_eff});
      @(posedge clk);
      pulse(1'b1);
      rchk("recover", 4'h2, 16'hF000);
      @(negedge clk);
      check("ratio 1:1", 16'h0000, {13'h0, doze_ratio_eff});
      @(posedge clk);
      wr(4'h2, 2'b10, 16'h7A00);
      pulse(1'b1);
      @(negedge clk);
      check("no recover", 16'h0007, {13'h0, doze_ratio_eff});
      @(posedge clk);
      wr(4'h2, 2'b01, 16'hFFFF);
      idle(2);
      rchk("lane off", 4'h2, 16'h7A00);
      wr(4'h2, 2'b10, 16'h7200);
      idle(3);
      @(negedge clk);
      check("ratio off", 16'h0000, {13'h0, doze_ratio_eff});
      @(posedge clk);
      for (int k = 0; k < 4; k++) begin
         wr(4'h4, 2'b01, {10'h000, trims[k]});
         idle(2);
         rchk("trim", 4'h4, {10'h000, trims[k]});
         @(negedge clk);
         check("trim out", {10'h000, trims[k]}, {10'h000, fast_rc_trim});
         @(posedge clk);
      end
      wr(4'h4, 2'b11, 16'hFFFF);
      idle(2);
      rchk("trim bits", 4'h4, 16'h003F);
      boot('{2'b10, 3'h5, 1'b1, 2'b10, 1'b0});
      @(negedge clk);
      check("fixed src", 16'h0005, {13'h0, sys_src});
      @(posedge clk);
      rchk("status", 4'h6, 16'h0220);
      unlock(1'b0, 16'h0041);
      rchk("start held", 4'h0, 16'h5540);
      unlock(1'b0, 16'h0000);
      rchk("one way", 4'h0, 16'h5540);
      summarize();
   end
endmodule
`default_nettype wire
